//--- bcce_defs.vh
/*
 * constants for the branch/call/clear/complement/watchdog-clear executor:
 * opcode patterns, phase codes, access-bank layout and reset values.
 * assumes plain Verilog-2005 includers.
 */
`ifndef BCCE_DEFS_VH
`define BCCE_DEFS_VH
// =====================================================================
// opcode patterns
`define BCCE_OP_BZ_HI      8'hE0
`define BCCE_OP_BOV_HI     8'hE4
`define BCCE_OP_CALL_HI7   7'h76
`define BCCE_OP_CALL2_HI4  4'hF
`define BCCE_OP_CLEAR_FILE_REGISTER_HI7   7'h35
`define BCCE_OP_INVERT_FILE_REGISTER_HI6   6'h07
`define BCCE_OP_CLEAR_WATCHDOG_INSTR     16'h0004
// =====================================================================
// field positions
`define BCCE_BIT_SAVE      8
`define BCCE_BIT_ACCESS    8
`define BCCE_BIT_DEST      9
`define BCCE_FLAG_N        4
`define BCCE_FLAG_OV       3
`define BCCE_FLAG_Z        2
// =====================================================================
// phase codes, one-hot
`define BCCE_Q1            4'h1
`define BCCE_Q2            4'h2
`define BCCE_Q3            4'h4
`define BCCE_Q4            4'h8
// =====================================================================
// access bank: low half maps to bank 0, high half to bank F
`define BCCE_ACC_SPLIT     8'h80
`define BCCE_ACC_HI_BANK   4'hF
`define BCCE_PC_RESET      21'h000000
`define BCCE_WORD_STEP     21'h000002
`define BCCE_CALL_RET_STEP 21'h000004
`define BCCE_ZERO_BYTE     8'h00
`endif

//--- bcce_phase_gen.v
/*
 * four-phase sequencer: rotates Q1..Q4 one clock each.
 * assumes one clock and a synchronous active-low reset.
 */
`default_nettype none
`include "bcce_defs.vh"
module bcce_phase_gen (
   input  wire       clock_in,   // core clock
   input  wire       rst_n_in,   // sync reset, low
   output wire [3:0] phase_out   // one-hot Q1..Q4
);
   reg [3:0] phase_reg;
   reg [3:0] phase_next;
   always @* begin
      case (phase_reg)
         `BCCE_Q1: phase_next = `BCCE_Q2;
         `BCCE_Q2: phase_next = `BCCE_Q3;
         `BCCE_Q3: phase_next = `BCCE_Q4;
         `BCCE_Q4: phase_next = `BCCE_Q1;
         default:  phase_next = `BCCE_Q1;
      endcase
   end
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         phase_reg <= `BCCE_Q1;
      end else begin
         phase_reg <= phase_next;
      end
   end
   assign phase_out = phase_reg;
endmodule // bcce_phase_gen
`default_nettype wire

//--- bcce_bank_addr.v
/*
 * data address former: access bank or bank select register.
 * assumes 12-bit data address space, combinational only.
 */
`default_nettype none
`include "bcce_defs.vh"
module bcce_bank_addr (
   input  wire        access_in,   // 0 access bank, 1 bank select
   input  wire [3:0]  bank_in,     // bank select value
   input  wire [7:0]  offset_in,   // f field
   output reg  [11:0] addr_out     // full data address
);
   always @* begin
      if (access_in) begin
         addr_out = {bank_in, offset_in};
      end else if (offset_in < `BCCE_ACC_SPLIT) begin
         addr_out = {4'h0, offset_in};
      end else begin
         addr_out = {`BCCE_ACC_HI_BANK, offset_in};
      end
   end
endmodule // bcce_bank_addr
`default_nettype wire

//--- bcce_exec.v
/*
 * executor for zero/overflow branches, two-word call with shadow save,
 * clear-register, complement-register and watchdog-clear.
 * assumes program memory answers a word address within the same instruction
 * cycle (word ready by Q1 after fetch) and data memory reads combinationally.
 */
`default_nettype none
`include "bcce_defs.vh"
// Function
// - zero-flag branch, opcode E0, redirects only when zero flag is one
// - taken target is incremented pc plus twice signed offset
// - branch one cycle untaken, two taken; pc written in Q4, then idle
// - overflow branch jumps when overflow set, else continues at here plus two
// - overflow branch decoded from upper byte E4 with signed low offset
// - call pushes call address plus four onto stack top
// - save bit copies accumulator, flags, bank select into shadows
// - call literal loads pc bits 20 through 1
// - call first word 1110110s with k7:0, second 1111 with k19:8
// - call two cycles: push in Q3, pc steps to word two in Q4; high literal and pc write in second Q4
// - clear-register writes zero to location in one cycle
// - access bit zero picks access bank, one picks bank select
// - watchdog-clear zeroes watchdog counter and postscaler
// - watchdog-clear encoding 0004 sets both low-active flags to one
// - complement goes to accumulator if dest zero, else to location
// - complement opcode 000111da updates negative and zero, one cycle
module bcce_exec (
   input  wire        clock_in,         // core clock, 40 MHz
   input  wire        rst_n_in,         // sync reset, low
   output wire [20:0] prog_addr_out,    // program word byte address
   input  wire [15:0] prog_word_in,     // program word at prog_addr_out
   output wire [11:0] data_addr_out,    // data memory address
   input  wire [7:0]  data_rd_in,       // data memory read value
   output reg  [7:0]  data_wr_out,      // data memory write value
   output reg         data_we_out,      // data write strobe, one cycle
   output reg  [20:0] stack_top_out,    // pushed return address
   output reg         stack_push_out,   // push strobe, one cycle
   output wire [7:0]  accumulator_out,  // accumulator
   output wire [7:0]  flags_out,        // flags register
   output wire [3:0]  bank_sel_reg_out, // bank select register
   input  wire        flags_we_in,      // external flags load
   input  wire [7:0]  flags_wdata_in,   // external flags value
   input  wire        bank_we_in,       // external bank select load
   input  wire [3:0]  bank_wdata_in,    // external bank select value
   output reg  [7:0]  accum_shadow_out, // accumulator shadow
   output reg  [7:0]  flags_shadow_out, // flags shadow
   output reg  [3:0]  bank_sel_shadow_out, // bank select shadow
   output reg         wdt_clear_out,    // watchdog counter+postscaler clear
   output reg         expiry_flag_low_out, // timeout flag, low active
   output reg         sleep_flag_low_out,  // power-down flag, low active
   input  wire        wdt_expire_in,    // watchdog timed out (same clock)
   input  wire        sleep_entry_in,   // core entered sleep (same clock)
   output wire [3:0]  phase_out         // current phase, one-hot
);
   // ==================================================================
   // states
   localparam [2:0] ST_EXEC  = 3'b001;
   localparam [2:0] ST_FLUSH = 3'b010;
   localparam [2:0] ST_CALL2 = 3'b100;

   reg  [20:0] pc_reg;
   reg  [20:0] pc_next;
   reg  [15:0] ir_reg;
   reg  [2:0]  state_reg;
   reg  [2:0]  state_next;
   reg  [7:0]  accum_reg;
   reg  [7:0]  flags_reg;
   reg  [3:0]  bank_reg;
   reg  [7:0]  klow_reg;
   wire [3:0]  phase;
   wire [7:0]  inverted;

   bcce_phase_gen u_phase (
      .clock_in  (clock_in),
      .rst_n_in  (rst_n_in),
      .phase_out (phase)
   );

   bcce_bank_addr u_addr (
      .access_in (ir_reg[`BCCE_BIT_ACCESS]),
      .bank_in   (bank_reg),
      .offset_in (ir_reg[7:0]),
      .addr_out  (data_addr_out)
   );

   // ==================================================================
   // decode helpers
   function is_bz;
      input [15:0] w;
      is_bz = (w[15:8] == `BCCE_OP_BZ_HI);
   endfunction
   function is_bov;
      input [15:0] w;
      is_bov = (w[15:8] == `BCCE_OP_BOV_HI);
   endfunction
   function [20:0] rel_target;
      input [20:0] pc_inc;
      input [7:0]  n;
      rel_target = pc_inc + {{12{n[7]}}, n, 1'b0};
   endfunction

   wire op_call  = (ir_reg[15:9] == `BCCE_OP_CALL_HI7);
   wire op_clear_file_register  = (ir_reg[15:9] == `BCCE_OP_CLEAR_FILE_REGISTER_HI7);
   wire op_invert_file_register  = (ir_reg[15:10] == `BCCE_OP_INVERT_FILE_REGISTER_HI6);
   wire op_clrwd = (ir_reg == `BCCE_OP_CLEAR_WATCHDOG_INSTR);
   wire br_taken = (is_bz(ir_reg) && flags_reg[`BCCE_FLAG_Z])
                || (is_bov(ir_reg) && flags_reg[`BCCE_FLAG_OV]);
   wire active   = (state_reg == ST_EXEC);

   assign inverted = ~data_rd_in;
   // during call's second word the program address is the address of word two, which holds the literal
   assign prog_addr_out = pc_reg;
   assign accumulator_out  = accum_reg;
   assign flags_out        = flags_reg;
   assign bank_sel_reg_out = bank_reg;
   assign phase_out        = phase;

   // ==================================================================
   // pc and state sequencing
   always @* begin
      pc_next    = pc_reg;
      state_next = state_reg;
      case (state_reg)
         ST_EXEC: begin
            if (phase == `BCCE_Q4) begin
               if (br_taken) begin
                  // offset applies to the incremented pc, flush adds nothing
                  pc_next    = rel_target(pc_reg + `BCCE_WORD_STEP, ir_reg[7:0]);
                  state_next = ST_FLUSH;
               end else if (op_call) begin
                  // step onto word two so its literal is on the bus next cycle
                  pc_next    = pc_reg + `BCCE_WORD_STEP;
                  state_next = ST_CALL2;
               end else begin
                  pc_next = pc_reg + `BCCE_WORD_STEP;
               end
            end
         end
         ST_CALL2: begin
            // word two is on prog_word_in here; load literal k19:0
            if (phase == `BCCE_Q4) begin
               pc_next    = {prog_word_in[11:0], klow_reg, 1'b0};
               state_next = ST_EXEC;
            end
         end
         ST_FLUSH: begin
            if (phase == `BCCE_Q4) begin
               state_next = ST_EXEC;
            end
         end
         default: begin
            state_next = ST_EXEC;
         end
      endcase
   end

   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         pc_reg    <= `BCCE_PC_RESET;
         state_reg <= ST_EXEC;
         ir_reg    <= 16'h0000;
         klow_reg  <= 8'h00;
      end else begin
         pc_reg    <= pc_next;
         state_reg <= state_next;
         if (phase == `BCCE_Q1 && state_next == ST_EXEC && state_reg == ST_EXEC) begin
            ir_reg <= prog_word_in;
         end else if (phase == `BCCE_Q1 && state_reg != ST_EXEC) begin
            ir_reg <= 16'h0000;
         end
         if (active && op_call && phase == `BCCE_Q2) begin
            klow_reg <= ir_reg[7:0];
         end
      end
   end

   // ==================================================================
   // data path, flags, shadows, watchdog
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         accum_reg           <= 8'h00;
         flags_reg           <= 8'h00;
         bank_reg            <= 4'h0;
         data_wr_out         <= 8'h00;
         data_we_out         <= 1'b0;
         stack_top_out       <= `BCCE_PC_RESET;
         stack_push_out      <= 1'b0;
         accum_shadow_out    <= 8'h00;
         flags_shadow_out    <= 8'h00;
         bank_sel_shadow_out <= 4'h0;
         wdt_clear_out       <= 1'b0;
         expiry_flag_low_out <= 1'b1;
         sleep_flag_low_out  <= 1'b1;
      end else begin
         data_we_out    <= 1'b0;
         stack_push_out <= 1'b0;
         wdt_clear_out  <= 1'b0;
         if (bank_we_in) begin
            bank_reg <= bank_wdata_in;
         end
         if (flags_we_in) begin
            flags_reg <= flags_wdata_in;
         end
         if (wdt_expire_in) begin
            expiry_flag_low_out <= 1'b0;
         end
         if (sleep_entry_in) begin
            sleep_flag_low_out <= 1'b0;
         end
         if (active && phase == `BCCE_Q3 && op_clrwd) begin
            wdt_clear_out       <= 1'b1;
            expiry_flag_low_out <= 1'b1;
            sleep_flag_low_out  <= 1'b1;
         end
         if (active && phase == `BCCE_Q3 && op_call) begin
            // pc still holds the call address in this cycle
            stack_top_out  <= pc_reg + `BCCE_CALL_RET_STEP;
            stack_push_out <= 1'b1;
            if (ir_reg[`BCCE_BIT_SAVE]) begin
               accum_shadow_out    <= accum_reg;
               flags_shadow_out    <= flags_reg;
               bank_sel_shadow_out <= bank_reg;
            end
         end
         if (active && phase == `BCCE_Q4 && op_clear_file_register) begin
            data_wr_out <= `BCCE_ZERO_BYTE;
            data_we_out <= 1'b1;
         end
         if (active && phase == `BCCE_Q4 && op_invert_file_register) begin
            if (ir_reg[`BCCE_BIT_DEST]) begin
               data_wr_out <= inverted;
               data_we_out <= 1'b1;
            end else begin
               accum_reg <= inverted;
            end
            flags_reg[`BCCE_FLAG_N] <= inverted[7];
            flags_reg[`BCCE_FLAG_Z] <= (inverted == `BCCE_ZERO_BYTE);
         end
      end
   end
endmodule // bcce_exec
`default_nettype wire

//--- bcce_exec_checker.sv
/* port-level assertions for the executor.
   assumes binding onto bcce_exec, one clock, synchronous low reset. */
`default_nettype none
module bcce_exec_checker (
   input wire logic        clock_in,            // core clock
   input wire logic        rst_n_in,            // sync reset, low
   input wire logic [20:0] prog_addr_out,       // executing word address
   input wire logic [20:0] stack_top_out,       // pushed address
   input wire logic        stack_push_out,      // push strobe
   input wire logic        data_we_out,         // data write strobe
   input wire logic        wdt_clear_out,       // watchdog clear strobe
   input wire logic        expiry_flag_low_out, // timeout flag
   input wire logic        sleep_flag_low_out,  // power-down flag
   input wire logic [3:0]  phase_out            // one-hot phase
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);
   // =====================================================================
   // assertions
   chk_push_ret_addr: assert property (stack_push_out |-> stack_top_out == prog_addr_out + 21'h000004)
      else $error("pushed address is not call address plus four");
   chk_push_in_q3: assert property (stack_push_out |-> phase_out == 4'h8)
      else $error("push not made on the third phase");
   chk_push_single: assert property (stack_push_out |=> !stack_push_out)
      else $error("push strobe longer than one clock");
   chk_pc_word_even: assert property (prog_addr_out[0] == 1'b0)
      else $error("program address is odd");
   chk_pc_q4_only: assert property (!$stable(prog_addr_out) |-> $past(phase_out) == 4'h8)
      else $error("program counter written outside the fourth phase");
   chk_phase_order: assert property (phase_out == 4'h8 |=> phase_out == 4'h1 ##1 phase_out == 4'h2)
      else $error("phase sequence broken");
   chk_we_single: assert property (data_we_out |=> !data_we_out [*3])
      else $error("data write strobe repeated within a cycle");
   chk_wdt_flags_set: assert property (wdt_clear_out |-> ##[0:2] (expiry_flag_low_out && sleep_flag_low_out))
      else $error("watchdog clear left a status flag low");
   chk_wdt_single: assert property (wdt_clear_out |=> !wdt_clear_out)
      else $error("watchdog clear strobe longer than one clock");
   cov_push: cover property (stack_push_out);
   cov_wdt: cover property (wdt_clear_out);
   cov_write: cover property (data_we_out);
endmodule // bcce_exec_checker
bind bcce_exec bcce_exec_checker u_bcce_exec_checker (.clock_in(clock_in), .rst_n_in(rst_n_in),
   .prog_addr_out(prog_addr_out), .stack_top_out(stack_top_out), .stack_push_out(stack_push_out),
   .data_we_out(data_we_out), .wdt_clear_out(wdt_clear_out), .phase_out(phase_out),
   .expiry_flag_low_out(expiry_flag_low_out), .sleep_flag_low_out(sleep_flag_low_out));
`default_nettype wire

//--- bcce_mem_model.sv
/* program and data memory seen by the executor.
   assumes combinational reads and writes on the strobe at the clock edge. */
`default_nettype none
module bcce_mem_model (
   input wire logic        clock_in,      // core clock
   input wire logic [20:0] prog_addr_in,  // program byte address
   output logic [15:0]     prog_word_out, // program word
   input wire logic [11:0] data_addr_in,  // data address
   input wire logic [7:0]  data_wr_in,    // write value
   input wire logic        data_we_in,    // write strobe
   output logic [7:0]      data_rd_out    // read value
);
   timeunit 1ns;
   timeprecision 1ps;
   // =====================================================================
   // storage, program side wraps at 1K bytes
   logic [15:0] prog_mem [0:511];
   logic [7:0]  data_mem [0:4095];
   assign prog_word_out = prog_mem[prog_addr_in[9:1]];
   assign data_rd_out = data_mem[data_addr_in];
   always @(posedge clock_in) begin
      if (data_we_in) begin
         data_mem[data_addr_in] <= data_wr_in;
      end
   end
endmodule // bcce_mem_model
`default_nettype wire

//--- branch_call_clear_exec_tb.sv
/* self-checking bench for the executor with its memory model.
   assumes 40 MHz clock and memories loaded while reset is held. */
`default_nettype none
module branch_call_clear_exec_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic flags_we_in = 1'b0;
   logic [7:0] flags_wdata_in = 8'h00;
   logic bank_we_in = 1'b0;
   logic [3:0] bank_wdata_in = 4'h0;
   logic wdt_expire_in = 1'b0;
   logic sleep_entry_in = 1'b0;
   wire [20:0] prog_addr, stack_top;
   wire [15:0] prog_word;
   wire [11:0] data_addr;
   wire [7:0] data_rd, data_wr, accum, flags, accum_sh, flags_sh;
   wire [3:0] bank, bank_sh, phase;
   wire data_we, push, wdt_clear, expiry_low, sleep_low;
   int n_mismatch = 0;
   int cmp_count = 0;
   int n_wdt = 0;
   always #12.5 clock_in = ~clock_in;
   always @(posedge clock_in) if (wdt_clear === 1'b1) n_wdt++;
   bcce_exec u_bcce_exec (.clock_in(clock_in), .rst_n_in(rst_n_in), .prog_addr_out(prog_addr),
      .prog_word_in(prog_word), .data_addr_out(data_addr), .data_rd_in(data_rd),
      .data_wr_out(data_wr), .data_we_out(data_we), .stack_top_out(stack_top),
      .stack_push_out(push), .accumulator_out(accum), .flags_out(flags),
      .bank_sel_reg_out(bank), .flags_we_in(flags_we_in), .flags_wdata_in(flags_wdata_in),
      .bank_we_in(bank_we_in), .bank_wdata_in(bank_wdata_in), .accum_shadow_out(accum_sh),
      .flags_shadow_out(flags_sh), .bank_sel_shadow_out(bank_sh), .wdt_clear_out(wdt_clear),
      .expiry_flag_low_out(expiry_low), .sleep_flag_low_out(sleep_low),
      .wdt_expire_in(wdt_expire_in), .sleep_entry_in(sleep_entry_in), .phase_out(phase));
   bcce_mem_model u_bcce_mem_model (.clock_in(clock_in), .prog_addr_in(prog_addr),
      .prog_word_out(prog_word), .data_addr_in(data_addr), .data_wr_in(data_wr),
      .data_we_in(data_we), .data_rd_out(data_rd));
   // =====================================================================
   // helpers
   task automatic check21(input logic [20:0] exp, input logic [20:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic check8(input logic [7:0] exp, input logic [7:0] got);
      check21({13'h0000, exp}, {13'h0000, got});
   endtask
   task automatic pw(input int a, input logic [15:0] w);
      u_bcce_mem_model.prog_mem[a / 2] = w;
   endtask
   function automatic logic [7:0] dm(input int a);
      return u_bcce_mem_model.data_mem[a];
   endfunction
   // memories reloaded under reset so no half-written program is fetched
   task automatic hold_reset();
      @(posedge clock_in);
      rst_n_in <= 1'b0;
      repeat (3) @(posedge clock_in);
      for (int i = 0; i < 512; i++) pw(2 * i, 16'h0000);
      for (int i = 0; i < 4096; i++) u_bcce_mem_model.data_mem[i] = 8'hFF;
   endtask
   task automatic go(input logic [7:0] fl, input logic [3:0] bk);
      @(posedge clock_in);
      rst_n_in <= 1'b1;
      flags_we_in <= 1'b1;
      flags_wdata_in <= fl;
      bank_we_in <= 1'b1;
      bank_wdata_in <= bk;
      @(posedge clock_in);
      flags_we_in <= 1'b0;
      bank_we_in <= 1'b0;
   endtask
   // =====================================================================
   // scenarios; taken path loops backwards through a negative offset
   task automatic test_branch(input logic [7:0] op, input logic [7:0] fl);
      for (int k = 0; k < 2; k++) begin
         hold_reset();
         pw(2, {op, 8'h04});
         pw(4, 16'h6A10);
         pw(6, 16'h6A11);
         pw(12, {op, 8'hFC});
         go(k ? fl : (fl ^ 8'h0C), 4'h0);
         repeat (20) @(posedge clock_in);
         #1;
         check21(k ? 21'h000006 : 21'h00000A, prog_addr);
         repeat (40) @(posedge clock_in);
         check8(k ? 8'hFF : 8'h00, dm(16));
         check8(8'h00, dm(17));
      end
      $display("branch test %h done", op);
   endtask
   task automatic test_call();
      for (int s = 0; s < 2; s++) begin
         hold_reset();
         u_bcce_mem_model.data_mem[32] = 8'h3C;
         pw(2, 16'h1C20);
         pw(4, {7'h76, s[0], 8'h40});
         pw(6, 16'hF001);
         pw(8, 16'h6A12);
         pw(640, 16'h6A13);
         go(8'h08, 4'h5);
         repeat (16) @(posedge clock_in);
         #1;
         check21(21'h000280, prog_addr);
         repeat (20) @(posedge clock_in);
         check21(21'h000008, stack_top);
         check8(8'hFF, dm(18));
         check8(8'h00, dm(19));
         check8(s ? 8'hC3 : 8'h00, accum_sh);
         check8(s ? 8'h18 : 8'h00, flags_sh);
         check8({4'h0, s ? 4'h5 : 4'h0}, {4'h0, bank_sh});
      end
      $display("call test done");
   endtask
   task automatic test_file();
      hold_reset();
      u_bcce_mem_model.data_mem[65] = 8'h13;
      pw(2, 16'h6B30);
      pw(4, 16'h6A85);
      pw(6, 16'h1C41);
      pw(8, 16'h1F40);
      go(8'h18, 4'h5);
      repeat (30) @(posedge clock_in);
      check8(8'h00, dm(12'h530));
      check8(8'hFF, dm(12'h030));
      check8(8'h00, dm(12'hF85));
      check8(8'h13, dm(12'h041));
      check8(8'hEC, accum);
      check8(8'h00, dm(12'h540));
      check8(8'h0C, flags);
      $display("clear and complement test done");
   endtask
   task automatic test_wdt();
      hold_reset();
      pw(8, 16'h0004);
      go(8'h00, 4'h0);
      wdt_expire_in <= 1'b1;
      sleep_entry_in <= 1'b1;
      @(posedge clock_in);
      wdt_expire_in <= 1'b0;
      sleep_entry_in <= 1'b0;
      repeat (3) @(posedge clock_in);
      #1;
      check8(8'h00, {6'h00, expiry_low, sleep_low});
      n_wdt = 0;
      repeat (20) @(posedge clock_in);
      #1;
      check8(8'h03, {6'h00, expiry_low, sleep_low});
      check8(8'h01, 8'(n_wdt));
      $display("watchdog clear test done");
   endtask
   // =====================================================================
   // run control
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      test_branch(8'hE0, 8'h04);
      test_branch(8'hE4, 8'h08);
      test_call();
      test_file();
      test_wdt();
      give_verdict();
   end
   // the whole sequence needs about 10 us
   initial begin
      #100000;
      n_mismatch++;
      give_verdict();
   end
endmodule // branch_call_clear_exec_tb
`default_nettype wire
